// *** tdmtx_pkg.sv ***
// Constants and types for the transmit slot map and clock monitor.
// Assumes a 16-bit register port and a 200 MHz system clock.
package tdmtx_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NUM_LINKS  = 16;
    localparam int NUM_REFS   = 4;
    localparam int SLOT_BITS  = 8;
    localparam int FRAME_BITS = 256;
    localparam logic [7:0] FRAME_LAST = 8'hFF;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [15:0] CTL_BASE   = 16'h0600;
    localparam logic [15:0] MAPL_BASE  = 16'h0610;
    localparam logic [15:0] MAPH_BASE  = 16'h0620;
    localparam logic [15:0] TXCKF_ADDR = 16'h0630;
    localparam logic [15:0] RXCKF_ADDR = 16'h0631;
    localparam logic [15:0] REFF_ADDR  = 16'h0632;
    localparam logic [15:0] SYNCF_ADDR = 16'h0633;
    localparam logic [15:0] ISTAT_ADDR = 16'h0640;
    localparam logic [15:0] IMASK_ADDR = 16'h0641;

    // ------------------------------------------------------------
    // Control fields and reset values
    // ------------------------------------------------------------
    localparam int CTL_POL_BIT = 0;
    localparam int CTL_FMT_BIT = 2;
    localparam int CTL_EN_BIT  = 7;
    localparam logic [15:0] REG_RST  = 16'h0000;
    localparam logic [15:0] CTL_MASK = 16'h0085;

    // ------------------------------------------------------------
    // Clock loss timing
    // ------------------------------------------------------------
    localparam int SYS_CLK_MHZ = 200;
    localparam int CLK_TMO_NS  = 1000;
    localparam int CLK_TMO_CYC = (CLK_TMO_NS * SYS_CLK_MHZ + 999) / 1000;

    // Per-link transmit control kept by this block
    typedef struct packed {
        logic en;   // Link enable
        logic fmt;  // 1: doubled clock format
        logic pol;  // Sync polarity, 1 active high
    } tdmtx_ctl_t;

endpackage

// *** tdmtx_slot_mon.sv ***
// Transmit TDM slot map, sync polarity and link clock health monitor.
// Assumes link clocks and syncs arrive asynchronously on pins and that
// software uses the one-cycle register port on i_clk.
//
// Overview of operation
// RL1: Control bit 0 picks sync polarity, 0 active low, 1 active high.
// RL2: In doubled clock format the polarity bit is ignored, sync low.
// RL3: Sixteen link control registers at consecutive addresses, reset zero.
// RL4: Low map bit n lets timeslot n, 0 to 15, carry traffic.
// RL5: Sixteen low map registers, one per link, reset to zero.
// RL6: High map bit n lets timeslot n+16 carry traffic, one per link.
// RL7: Data output is released, not driven, in unmapped timeslots.
// RL8: Software keeps high map bit 8 clear on T1 links.
// RL9: Read-only register shows transmit clock fault of each link.
// RL10: Read-only register shows receive clock fault of each link.
// RL11: Reference clock faults in bits 3 to 0, upper bits zero.
// RL12: Sync fault flag per link stays set until software writes 0.
// RL13: Format bit picks generic 1x clock or doubled 2x clock format.
// RL14: Link enable clear releases the whole transmit port.
// RL15: Clock faulty after a silent timeout; sync faulty if missing.
// RL16: Clock fault bits are live synchronised state; reads harmless.
module tdmtx_slot_mon #(
    parameter int TMO_CYC = tdmtx_pkg::CLK_TMO_CYC  // Clock loss count
) (
    input  wire logic        i_clk,                   // System clock
    input  wire logic        i_rst_b,                 // Sync reset, low
    input  wire logic [15:0] i_addr,                  // Register address
    input  wire logic [15:0] i_wdata,                 // Write data
    input  wire logic        i_wr,                    // Write strobe
    input  wire logic        i_rd,                    // Read strobe
    output logic      [15:0] o_rdata,                 // Read data
    output logic             o_irq,                   // Interrupt level
    input  wire logic [15:0] i_tx_link_clock,         // Tx link clocks
    input  wire logic [15:0] i_rx_link_clock,         // Rx link clocks
    input  wire logic [3:0]  i_reference_clock_input, // Reference clocks
    input  wire logic [15:0] i_tx_frame_sync,         // Tx frame syncs
    input  wire logic [15:0] i_tx_data,               // Serial data in
    output logic      [15:0] o_tx_serial_data_out,    // Serial data out
    output logic      [15:0] o_tx_serial_data_oe      // Output enable
);

    // ------------------------------------------------------------
    // Local sizes
    // ------------------------------------------------------------
    localparam int NL  = tdmtx_pkg::NUM_LINKS;
    localparam int NCK = 2 * NL + tdmtx_pkg::NUM_REFS;
    localparam int NIN = NCK + NL;
    localparam int SYB = NCK;
    localparam int CW  = $clog2(TMO_CYC + 1);
    localparam logic [CW-1:0] TMO_W = CW'(TMO_CYC);

    logic [NIN-1:0] raw;
    logic [NIN-1:0] sy1;
    logic [NIN-1:0] sy2;
    logic [NIN-1:0] sy3;
    logic [NIN-1:0] st;
    logic [NIN-1:0] pst;
    logic [NCK-1:0] ckflt;
    logic [NL-1:0]  sev;
    logic [NL-1:0]  sflag;
    logic [NL-1:0]  istat;
    logic [NL-1:0]  imask;
    logic [15:0]    mapl [NL];
    logic [15:0]    maph [NL];
    logic [15:0]    ctl_rd;
    logic [3:0]     idx;
    logic           wr_ctl;
    logic           wr_mapl;
    logic           wr_maph;
    logic           wr_sync;
    logic [NL-1:0]  clrv;
    tdmtx_pkg::tdmtx_ctl_t ctl [NL];

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    assign raw = {i_tx_frame_sync, i_reference_clock_input,
                  i_rx_link_clock, i_tx_link_clock};

    // Settled level moves only when stages two and three agree
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            sy1 <= '0;
            sy2 <= '0;
            sy3 <= '0;
            st  <= '0;
            pst <= '0;
        end else begin
            sy1 <= raw;
            sy2 <= sy1;
            sy3 <= sy2;
            st  <= (st & (sy2 ^ sy3)) | (sy3 & ~(sy2 ^ sy3));
            pst <= st;
        end
    end

    // ------------------------------------------------------------
    // Clock loss detectors
    // ------------------------------------------------------------
    for (genvar k = 0; k < NCK; k++) begin : g_ck
        logic [CW-1:0] cnt;

        // RL15: silence timeout count
        always_ff @(posedge i_clk) begin
            if (!i_rst_b) begin
                cnt <= '0;
            end else if (st[k] != pst[k]) begin
                cnt <= '0;
            end else if (cnt != TMO_W) begin
                cnt <= cnt + 1'b1;
            end
        end

        // RL16: live fault level, clears on next edge
        always_ff @(posedge i_clk) begin
            if (!i_rst_b) begin
                ckflt[k] <= 1'b0;
            end else begin
                ckflt[k] <= (cnt == TMO_W);
            end
        end

        AST_CKF: assert property ($rose(ckflt[k]) |->   // RL15
            $past(cnt, 2) == TMO_W - 1'b1)
            else $error("clock fault raised early");
    end

    // ------------------------------------------------------------
    // Transmit links
    // ------------------------------------------------------------
    for (genvar i = 0; i < NL; i++) begin : g_ln
        logic       edge_t;
        logic       adv;
        logic       sact;
        logic       half;
        logic [7:0] bcnt;
        logic [7:0] nb;
        logic [31:0] mapw;

        assign edge_t = st[i] & ~pst[i];
        assign mapw   = {maph[i], mapl[i]};

        // RL13: doubled clock advances every second edge
        assign adv = edge_t & (~ctl[i].fmt | half);

        // RL1: polarity picks the active sync level
        // RL2: doubled format fixes sync active low
        assign sact = ctl[i].fmt ? ~st[SYB+i]
                                 : (st[SYB+i] == ctl[i].pol);

        assign nb = sact ? 8'h00 : bcnt + 8'h01;

        // Half-bit phase of the doubled clock
        always_ff @(posedge i_clk) begin
            if (!i_rst_b || !ctl[i].en) begin
                half <= 1'b0;
            end else if (edge_t && ctl[i].fmt) begin
                half <= ~half;
            end
        end

        // Bit position in the frame, realigned by sync
        always_ff @(posedge i_clk) begin
            if (!i_rst_b) begin
                bcnt <= 8'h00;
            end else if (adv) begin
                bcnt <= nb;
            end
        end

        // RL15: sync missing at the frame boundary
        assign sev[i] = adv & ctl[i].en & ~sact
                        & (bcnt == tdmtx_pkg::FRAME_LAST);

        // RL14: disabled link releases its port
        // RL7: unmapped slot releases data output
        always_ff @(posedge i_clk) begin
            if (!i_rst_b) begin
                o_tx_serial_data_out[i] <= 1'b0;
                o_tx_serial_data_oe[i]  <= 1'b0;
            end else if (!ctl[i].en) begin
                o_tx_serial_data_oe[i]  <= 1'b0;
            end else if (adv) begin
                o_tx_serial_data_out[i] <= i_tx_data[i];
                // RL4: slot map selects the slot
                o_tx_serial_data_oe[i]  <= mapw[nb[7:3]];
            end
        end

        AST_POL: assert property (adv && !ctl[i].fmt &&   // RL1
            st[SYB+i] == ctl[i].pol |=> bcnt == 8'h00)
            else $error("generic sync did not realign");
        AST_DBL: assert property (adv && ctl[i].fmt &&    // RL2
            !st[SYB+i] |=> bcnt == 8'h00)
            else $error("doubled sync did not realign");
        AST_OE: assert property (adv && ctl[i].en &&      // RL7
            !i_wr |=> o_tx_serial_data_oe[i] == mapw[bcnt[7:3]])
            else $error("enable does not follow slot map");
        AST_EN: assert property (!ctl[i].en |=>           // RL14
            !o_tx_serial_data_oe[i])
            else $error("disabled link still drives");
    end

    // ------------------------------------------------------------
    // Register write decode
    // ------------------------------------------------------------
    assign idx     = i_addr[3:0];
    assign wr_ctl  = i_wr && i_addr[15:4] == tdmtx_pkg::CTL_BASE[15:4];
    assign wr_mapl = i_wr && i_addr[15:4] == tdmtx_pkg::MAPL_BASE[15:4];
    assign wr_maph = i_wr && i_addr[15:4] == tdmtx_pkg::MAPH_BASE[15:4];
    assign wr_sync = i_wr && i_addr == tdmtx_pkg::SYNCF_ADDR;
    assign clrv    = wr_sync ? ~i_wdata : '0;

    // RL3: link control registers
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            for (int n = 0; n < NL; n++) begin
                ctl[n] <= '0;
            end
        end else if (wr_ctl) begin
            ctl[idx].en  <= i_wdata[tdmtx_pkg::CTL_EN_BIT];
            ctl[idx].fmt <= i_wdata[tdmtx_pkg::CTL_FMT_BIT];
            ctl[idx].pol <= i_wdata[tdmtx_pkg::CTL_POL_BIT];
        end
    end

    // RL5: low slot maps
    // RL6: high slot maps
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            for (int n = 0; n < NL; n++) begin
                mapl[n] <= tdmtx_pkg::REG_RST;
                maph[n] <= tdmtx_pkg::REG_RST;
            end
        end else begin
            if (wr_mapl) begin
                mapl[idx] <= i_wdata;
            end
            if (wr_maph) begin
                maph[idx] <= i_wdata;
            end
        end
    end

    // RL12: write 0 clears, new fault wins
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            sflag <= '0;
        end else begin
            sflag <= (sflag & ~clrv) | sev;
        end
    end

    // ------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------
    // Write one clears; a same-cycle event keeps its bit set
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            istat <= '0;
            imask <= '0;
            o_irq <= 1'b0;
        end else begin
            if (i_wr && i_addr == tdmtx_pkg::ISTAT_ADDR) begin
                istat <= (istat & ~i_wdata) | sev;
            end else begin
                istat <= istat | sev;
            end
            if (i_wr && i_addr == tdmtx_pkg::IMASK_ADDR) begin
                imask <= i_wdata;
            end
            o_irq <= |(istat & imask);
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Only the kept control fields read back, others as zero
    always_comb begin
        ctl_rd = tdmtx_pkg::REG_RST;
        ctl_rd[tdmtx_pkg::CTL_EN_BIT]  = ctl[idx].en;
        ctl_rd[tdmtx_pkg::CTL_FMT_BIT] = ctl[idx].fmt;
        ctl_rd[tdmtx_pkg::CTL_POL_BIT] = ctl[idx].pol;
    end

    // RL9: tx clock faults
    // RL10: rx clock faults
    // RL11: reference faults, upper bits zero
    // Data valid one cycle after the strobe, zero otherwise
    always_ff @(posedge i_clk) begin
        if (!i_rst_b || !i_rd) begin
            o_rdata <= '0;
        end else if (i_addr[15:4] == tdmtx_pkg::CTL_BASE[15:4]) begin
            o_rdata <= ctl_rd;
        end else if (i_addr[15:4] == tdmtx_pkg::MAPL_BASE[15:4]) begin
            o_rdata <= mapl[idx];
        end else if (i_addr[15:4] == tdmtx_pkg::MAPH_BASE[15:4]) begin
            o_rdata <= maph[idx];
        end else if (i_addr == tdmtx_pkg::TXCKF_ADDR) begin
            o_rdata <= ckflt[NL-1:0];
        end else if (i_addr == tdmtx_pkg::RXCKF_ADDR) begin
            o_rdata <= ckflt[2*NL-1:NL];
        end else if (i_addr == tdmtx_pkg::REFF_ADDR) begin
            o_rdata <= {12'h000, ckflt[NCK-1:2*NL]};
        end else if (i_addr == tdmtx_pkg::SYNCF_ADDR) begin
            o_rdata <= sflag;
        end else if (i_addr == tdmtx_pkg::ISTAT_ADDR) begin
            o_rdata <= istat;
        end else if (i_addr == tdmtx_pkg::IMASK_ADDR) begin
            o_rdata <= imask;
        end else begin
            o_rdata <= '0;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_CTL: assert property (wr_ctl ##1 i_rd &&         // RL3
        i_addr == $past(i_addr) |=>
        o_rdata == ($past(i_wdata, 2) & tdmtx_pkg::CTL_MASK))
        else $error("control readback mismatch");
    AST_MAP: assert property (wr_mapl ##1 i_rd &&        // RL5
        i_addr == $past(i_addr) |=> o_rdata == $past(i_wdata, 2))
        else $error("low map readback mismatch");
    AST_TXF: assert property (i_rd &&                    // RL9
        i_addr == tdmtx_pkg::TXCKF_ADDR |=>
        o_rdata == $past(ckflt[NL-1:0]))
        else $error("tx clock fault read wrong");
    AST_RXF: assert property (i_rd &&                    // RL10
        i_addr == tdmtx_pkg::RXCKF_ADDR |=>
        o_rdata == $past(ckflt[2*NL-1:NL]))
        else $error("rx clock fault read wrong");
    AST_REF: assert property (i_rd &&                    // RL11
        i_addr == tdmtx_pkg::REFF_ADDR |=> o_rdata[15:4] == 12'h000)
        else $error("reference fault upper bits set");
    AST_SYF: assert property (1'b1 |=>                    // RL12
        ($past(sflag & ~clrv) & ~sflag) == '0)
        else $error("sync fault flag lost");
    AST_RDZ: assert property (!i_rd |=> o_rdata == 16'h0000) // RL16
        else $error("read data outside read cycle");
    AST_IRQ: assert property ((istat & imask) != '0 |=> o_irq)
        else $error("interrupt missing");

    COV_SEV: cover property (sev != '0);
    COV_IRQ: cover property ($rose(o_irq));
    COV_CKF: cover property (ckflt != '0);
    COV_OE:  cover property ($rose(o_tx_serial_data_oe[0]));

endmodule

// *** tdmtx_framer_model.sv ***
// Framer model for one transmit link: link clock, frame sync, bit index.
// Assumes the monitor samples these pins with its own system clock.
module tdmtx_framer_model #(
    parameter int   EDGES = 1,    // Link clock edges per bit
    parameter logic ACT   = 1'b1  // Active sync level
) (
    input  wire logic       i_run,  // Clock runs while high
    input  wire logic       i_drop, // Omit sync pulses
    output logic            o_clk,  // Link clock
    output logic            o_sync, // Frame sync
    output logic      [7:0] o_bit   // Bit of frame now on the line
);
    timeunit 1ns;
    timeprecision 100ps;

    // --------------------------------------------------------
    // Idle levels, then link clock and sync
    // --------------------------------------------------------
    // edges per bit, sync level
    // One process owns every output, so each pin has a single driver
    // Sync spans every edge of bit 0, so either doubled phase sees it once
    initial begin
        o_clk = 1'b0;
        o_sync = ~ACT;
        o_bit = 8'hFF;
        forever begin
            if (!i_run) begin
                #62.5;  // Clock stands still while i_run is low
            end else begin
                for (int e = 0; e < EDGES; e++) begin
                    o_clk = 1'b1;
                    if (e == 0) begin
                        o_bit = o_bit + 8'h01;
                    end
                    #62.5;
                    o_clk = 1'b0;
                    if (e == EDGES - 1 && o_bit == 8'hFF && !i_drop) begin
                        o_sync = ACT;
                    end else if (e == EDGES - 1 && o_bit == 8'h00) begin
                        o_sync = ~ACT;
                    end
                    #62.5;
                end
            end
        end
    end
endmodule

// *** tdm_tx_slot_map_clock_monitor_tb_top.sv ***
// Testbench: register access, slot map output, clock and sync faults.
// Assumes the framer model drives links 0 to 2; other links stay idle.
module tdm_tx_slot_map_clock_monitor_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    // --------------------------------------------------------
    // Signals
    // --------------------------------------------------------
    localparam int TMO = 16;  // Above half a link period
    logic        clk = 1'b0;
    logic        rst_b;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [15:0] pat;
    logic        wr_s;
    logic        rd_s;
    logic [15:0] rdata;
    logic        irq;
    logic [15:0] tx_data;
    logic [15:0] dout;
    logic [15:0] oe;
    logic [2:0]  lclk;
    logic [2:0]  lsync;
    logic [7:0]  bit_idx [3];
    logic        run;
    logic        drop;
    int          miscompares = 0;
    int          total_checks = 0;
    logic [31:0] maps [3] = '{32'h4001_8001, 32'h8000_00F0, 32'h0000_0F0F};
    logic [15:0] ctls [3] = '{16'h0081, 16'h0080, 16'h0085};

    // Clock
    always #2.5 clk = ~clk;

    tdmtx_slot_mon #(.TMO_CYC(TMO)) dut_u (
        .i_clk                   (clk),
        .i_rst_b                 (rst_b),
        .i_addr                  (addr),
        .i_wdata                 (wdata),
        .i_wr                    (wr_s),
        .i_rd                    (rd_s),
        .o_rdata                 (rdata),
        .o_irq                   (irq),
        .i_tx_link_clock         ({13'h0000, lclk}),
        .i_rx_link_clock         ({13'h0000, lclk}),
        .i_reference_clock_input ({3'h0, lclk[0]}),
        .i_tx_frame_sync         ({13'h0000, lsync}),
        .i_tx_data               (tx_data),
        .o_tx_serial_data_out    (dout),
        .o_tx_serial_data_oe     (oe)
    );

    // Link 2 doubled and sync low; link 1 active low sync
    for (genvar g = 0; g < 3; g++) begin : g_frm
        tdmtx_framer_model #(.EDGES(g == 2 ? 2 : 1), .ACT(g == 0)) frm_u (
            .i_run  (run),
            .i_drop (g == 1 ? drop : 1'b0),
            .o_clk  (lclk[g]),
            .o_sync (lsync[g]),
            .o_bit  (bit_idx[g])
        );
    end

    // --------------------------------------------------------
    // Tasks
    // --------------------------------------------------------
    task automatic chk(input string nm, input logic [15:0] exp,
                       input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), exp, rdata);
    endtask

    // Write then read back with no idle cycle between the strobes
    task automatic wr_rd(input logic [15:0] a, input logic [15:0] d,
                         input logic [15:0] exp);
        wr(a, d);
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), exp, rdata);
    endtask

    // Samples mid-slot, so half a doubled bit of phase does not matter
    task automatic scan(input int l);
        for (int s = 0; s < 32; s++) begin
            wait (bit_idx[l] == 8'(s * 8 + 4));
            repeat (10) @(posedge clk);
            #1;
            chk("oe", {15'h0000, maps[l][s]}, {15'h0000, oe[l]});
            if (maps[l][s]) begin
                chk("data", {15'h0, tx_data[l]}, {15'h0, dout[l]});
            end
            chk("idle oe", 16'h0000, {3'h0, oe[15:3]});
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // --------------------------------------------------------
    // Tests
    // --------------------------------------------------------
    initial begin
        rst_b = 1'b0;
        addr = 16'h0000;
        wdata = 16'h0000;
        wr_s = 1'b0;
        rd_s = 1'b0;
        tx_data = 16'h0005;
        run = 1'b0;
        drop = 1'b0;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        for (int n = 0; n < 4; n++) begin
            rd(tdmtx_pkg::TXCKF_ADDR + 16'(n), 16'h0000);
        end
        for (int n = 0; n < 48; n++) begin
            rd(16'h0600 + 16'(n), 16'h0000);
        end
        for (int n = 0; n < 16; n++) begin
            pat = tdmtx_pkg::CTL_BASE + 16'(n);
            wr_rd(pat, 16'hFFFF, tdmtx_pkg::CTL_MASK);
            wr(pat, 16'h0000);
        end
        for (int n = 16; n < 48; n++) begin
            pat = 16'hA5C3 ^ 16'(n);
            wr_rd(16'h0600 + 16'(n), pat, pat);
        end
        wr(tdmtx_pkg::TXCKF_ADDR, 16'h1234);
        rd(tdmtx_pkg::TXCKF_ADDR, 16'hFFFF);
        rd(tdmtx_pkg::RXCKF_ADDR, 16'hFFFF);
        rd(tdmtx_pkg::REFF_ADDR, 16'h000F);
        rd(tdmtx_pkg::REFF_ADDR, 16'h000F);
        rd(16'h0700, 16'h0000);
        $display("test registers done");
        // Link 0 is a T1 link: high map bit 8 stays clear
        for (int l = 0; l < 3; l++) begin
            wr(tdmtx_pkg::MAPL_BASE + 16'(l), maps[l][15:0]);
            wr(tdmtx_pkg::MAPH_BASE + 16'(l), maps[l][31:16]);
            wr(tdmtx_pkg::CTL_BASE + 16'(l), ctls[l]);
        end
        run <= 1'b1;
        repeat (13000) @(posedge clk);
        rd(tdmtx_pkg::TXCKF_ADDR, 16'hFFF8);
        rd(tdmtx_pkg::RXCKF_ADDR, 16'hFFF8);
        rd(tdmtx_pkg::REFF_ADDR, 16'h000E);
        // Faults from before the first sync are cleared away
        wr(tdmtx_pkg::SYNCF_ADDR, 16'h0000);
        wr(tdmtx_pkg::ISTAT_ADDR, 16'hFFFF);
        fork
            scan(0);
            scan(1);
            scan(2);
        join
        rd(tdmtx_pkg::SYNCF_ADDR, 16'h0000);
        rd(tdmtx_pkg::ISTAT_ADDR, 16'h0000);
        $display("test slot map done");
        drop <= 1'b1;
        repeat (7000) @(posedge clk);
        drop <= 1'b0;
        repeat (7000) @(posedge clk);
        rd(tdmtx_pkg::SYNCF_ADDR, 16'h0002);
        rd(tdmtx_pkg::ISTAT_ADDR, 16'h0002);
        chk("irq masked", 16'h0000, {15'h0000, irq});
        wr(tdmtx_pkg::IMASK_ADDR, 16'h0002);
        repeat (2) @(posedge clk);
        #1;
        chk("irq", 16'h0001, {15'h0000, irq});
        wr(tdmtx_pkg::SYNCF_ADDR, 16'hFFFF);
        rd(tdmtx_pkg::SYNCF_ADDR, 16'h0002);
        wr(tdmtx_pkg::SYNCF_ADDR, 16'h0000);
        rd(tdmtx_pkg::SYNCF_ADDR, 16'h0000);
        wr(tdmtx_pkg::ISTAT_ADDR, 16'h0002);
        repeat (2) @(posedge clk);
        #1;
        chk("irq clear", 16'h0000, {15'h0000, irq});
        wr(tdmtx_pkg::CTL_BASE, 16'h0000);
        repeat (3) @(posedge clk);
        #1;
        chk("oe off", 16'h0000, {15'h0000, oe[0]});
        $display("test faults done");
        tally_and_finish();
    end

    // Watchdog: tests need about 40000 cycles
    initial begin
        repeat (90000) @(posedge clk);
        miscompares++;
        tally_and_finish();
    end
endmodule
